// [rtl/oag_operand_address_generator.sv]
`timescale 1ns/1ns
`default_nettype none
module oag_operand_address_generator (
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Operand request from decode.
	input  wire logic              req_valid,
	input  wire oag_pkg::oag_mode_t req_mode,
	input  wire logic        [7:0] req_field,
	input  wire logic        [2:0] req_reg_sel,
	input  wire logic              req_ptr_sel,
	input  wire logic              req_xdata,
	input  wire logic              req_write,
	input  wire logic              req_acc_data,
	// Core state.
	input  wire logic        [1:0] bank_sel,
	input  wire logic        [7:0] acc,
	input  wire logic       [15:0] data_pointer,
	input  wire logic        [7:0] pointer_reg_a,
	input  wire logic        [7:0] pointer_reg_b,
	// Resolved operand.
	output logic                   op_valid,
	output oag_pkg::oag_space_t    op_space,
	output logic            [15:0] op_addr,
	output logic             [7:0] op_imm,
	output logic             [2:0] op_bit_sel,
	output logic                   op_is_bit,
	output logic                   op_spec_byte,
	output logic                   op_error
);

	typedef struct packed {
		logic                rst_s1;
		logic                rst_s2;
		logic                valid;
		oag_pkg::oag_space_t space;
		logic [15:0]         addr;
		logic [7:0]          imm;
		logic [2:0]          bit_sel;
		logic                is_bit;
		logic                spec_byte;
		logic                error;
	} oag_state_t;

	oag_state_t state_q;
	oag_state_t state_d;
	logic       rst_q;
	logic [7:0] bit_byte;
	logic [2:0] bit_pos;
	logic       bit_in_special_function_reg;

	// Working register address inside internal RAM: eight bytes per bank.
	function automatic logic [15:0] oag_reg_addr(input logic [1:0] bank, input logic [2:0] sel);
		oag_reg_addr = {11'h000, bank, sel};
	endfunction

	// Zero-extends a byte address into the answer's address width.
	function automatic logic [15:0] oag_byte_addr(input logic [7:0] a);
		oag_byte_addr = {8'h00, a};
	endfunction

	assign rst_q = state_q.rst_s2;

	oag_bit_decode oag_bit_decode_inst (
		.bit_addr                (req_field),
		.byte_addr               (bit_byte),
		.bit_sel                 (bit_pos),
		.in_special_function_reg (bit_in_special_function_reg)
	);

	// Resolves one request per cycle; the answer is registered so it holds for one cycle.
	always_comb begin
		state_d = state_q;
		state_d.rst_s1 = 1'b1;
		state_d.rst_s2 = state_q.rst_s1;
		state_d.valid = 1'b0;
		state_d.space = oag_pkg::SPACE_NONE;
		state_d.addr = oag_pkg::ADDR_RST;
		state_d.imm = oag_pkg::IMM_RST;
		state_d.bit_sel = oag_pkg::BIT_RST;
		state_d.is_bit = 1'b0;
		state_d.spec_byte = 1'b0;
		state_d.error = 1'b0;
		if (rst_q && req_valid) begin
			state_d.valid = 1'b1;
			state_d.spec_byte = 1'b1;
			case (req_mode)
				oag_pkg::MODE_DIRECT: begin
					state_d.addr = oag_byte_addr(req_field);
					if (req_field >= oag_pkg::SPECIAL_FUNCTION_REG_BASE) begin
						state_d.space = oag_pkg::SPACE_SPECIAL_FUNCTION_REG;
					end else begin
						state_d.space = oag_pkg::SPACE_IRAM;
					end
				end
				oag_pkg::MODE_IND8: begin
					// Pointer contents address RAM, or external RAM for a data move.
					state_d.addr = oag_byte_addr(req_ptr_sel ? pointer_reg_b : pointer_reg_a);
					state_d.space = req_xdata ? oag_pkg::SPACE_XRAM : oag_pkg::SPACE_IRAM;
				end
				oag_pkg::MODE_IND16: begin
					state_d.addr = data_pointer;
					state_d.space = oag_pkg::SPACE_XRAM;
				end
				oag_pkg::MODE_REG: begin
					state_d.addr = oag_reg_addr(bank_sel, req_reg_sel);
					state_d.space = oag_pkg::SPACE_IRAM;
					state_d.spec_byte = 1'b0;
				end
				oag_pkg::MODE_IMPLIED: begin
					state_d.space = oag_pkg::SPACE_ACC;
					state_d.spec_byte = 1'b0;
				end
				oag_pkg::MODE_IMM: begin
					state_d.space = oag_pkg::SPACE_IMM;
					state_d.imm = req_field;
				end
				oag_pkg::MODE_INDEXED: begin
					state_d.space = oag_pkg::SPACE_CODE;
					state_d.addr = 16'(data_pointer + {8'h00, acc});
				end
				oag_pkg::MODE_BIT: begin
					state_d.is_bit = 1'b1;
					state_d.bit_sel = bit_pos;
					state_d.addr = oag_byte_addr(bit_byte);
					state_d.space = bit_in_special_function_reg
						? oag_pkg::SPACE_SPECIAL_FUNCTION_REG : oag_pkg::SPACE_IRAM;
				end
				default: begin
					state_d.error = 1'b1;
				end
			endcase
			// Illegal combinations are flagged rather than silently redirected.
			if ((req_mode == oag_pkg::MODE_INDEXED) && req_write) begin
				state_d.error = 1'b1;
			end
			if (req_xdata && (((req_mode != oag_pkg::MODE_IND8)
				&& (req_mode != oag_pkg::MODE_IND16)) || !req_acc_data)) begin
				state_d.error = 1'b1;
			end
			if ((req_mode == oag_pkg::MODE_IND16) && !req_xdata) begin
				state_d.error = 1'b1;
			end
			if (state_d.error) begin
				state_d.space = oag_pkg::SPACE_NONE;
				state_d.addr = oag_pkg::ADDR_RST;
				state_d.imm = oag_pkg::IMM_RST;
				state_d.is_bit = 1'b0;
				state_d.bit_sel = oag_pkg::BIT_RST;
			end
		end
	end

	// Asynchronous reset loads constants only; release is seen through the two sync stages.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Every output is a flip-flop of the state.
	assign op_valid     = state_q.valid;
	assign op_space     = state_q.space;
	assign op_addr      = state_q.addr;
	assign op_imm       = state_q.imm;
	assign op_bit_sel   = state_q.bit_sel;
	assign op_is_bit    = state_q.is_bit;
	assign op_spec_byte = state_q.spec_byte;
	assign op_error     = state_q.error;

	// Checks compare each answer with the request taken one edge before.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n || !rst_q);

	logic req_ok;
	assign req_ok = req_valid && !req_xdata && !req_write;

	a_valid_one_cycle: assert property ($past(rst_q && req_valid) == op_valid)
		else $error("answer valid does not follow request");
	a_direct_space: assert property (req_ok && req_mode == oag_pkg::MODE_DIRECT
		|=> op_space == (($past(req_field) >= oag_pkg::SPECIAL_FUNCTION_REG_BASE)
		? oag_pkg::SPACE_SPECIAL_FUNCTION_REG : oag_pkg::SPACE_IRAM)
		&& op_addr == {8'h00, $past(req_field)})
		else $error("direct address wrong");
	a_ind8_pointer: assert property (req_ok && req_mode == oag_pkg::MODE_IND8
		|=> op_addr[7:0] == ($past(req_ptr_sel) ? $past(pointer_reg_b) : $past(pointer_reg_a)))
		else $error("pointer indirect address wrong");
	a_ind16_pointer: assert property (req_valid && req_xdata && req_acc_data
		&& req_mode == oag_pkg::MODE_IND16 |=> op_addr == $past(data_pointer)
		&& op_space == oag_pkg::SPACE_XRAM)
		else $error("data pointer indirect wrong");
	a_reg_bank_sel: assert property (req_ok && req_mode == oag_pkg::MODE_REG
		|=> op_addr == {11'h000, $past(bank_sel), $past(req_reg_sel)} && !op_spec_byte)
		else $error("register address wrong");
	a_implied_acc: assert property (req_ok && req_mode == oag_pkg::MODE_IMPLIED
		|=> op_space == oag_pkg::SPACE_ACC && !op_spec_byte)
		else $error("implied operand wrong");
	a_imm_value: assert property (req_ok && req_mode == oag_pkg::MODE_IMM
		|=> op_space == oag_pkg::SPACE_IMM && op_imm == $past(req_field))
		else $error("immediate value wrong");
	a_indexed_read: assert property (req_valid && req_mode == oag_pkg::MODE_INDEXED
		|=> (op_error == ($past(req_write) || $past(req_xdata)))
		&& (op_error || op_addr == 16'($past(data_pointer) + {8'h00, $past(acc)})))
		else $error("indexed read wrong");
	a_bit_map: assert property (req_ok && req_mode == oag_pkg::MODE_BIT
		|=> op_is_bit && op_bit_sel == $past(req_field[2:0])
		&& (op_space == oag_pkg::SPACE_SPECIAL_FUNCTION_REG)
		== ($past(req_field) >= oag_pkg::BIT_SPECIAL_FUNCTION_REG_BASE))
		else $error("bit address mapping wrong");
	a_xdata_acc_only: assert property (op_space == oag_pkg::SPACE_XRAM
		|-> $past(req_acc_data) && $past(req_xdata) && !op_error)
		else $error("external RAM access not accumulator indirect");

	c_direct_special: cover property (op_valid && !op_is_bit
		&& op_space == oag_pkg::SPACE_SPECIAL_FUNCTION_REG);
	c_bit_special: cover property (op_valid && op_is_bit
		&& op_space == oag_pkg::SPACE_SPECIAL_FUNCTION_REG);
	c_indexed: cover property (op_valid && op_space == oag_pkg::SPACE_CODE);
	c_error: cover property (op_valid && op_error);

endmodule
`default_nettype wire

// [rtl/oag_pkg.sv]
`default_nettype none
package oag_pkg;

	// Addressing mode requested by the decoder for one operand.
	typedef enum logic [2:0] {
		MODE_DIRECT,
		MODE_IND8,
		MODE_IND16,
		MODE_REG,
		MODE_IMPLIED,
		MODE_IMM,
		MODE_INDEXED,
		MODE_BIT
	} oag_mode_t;

	// Space in which the resolved operand lives.
	typedef enum logic [2:0] {
		SPACE_NONE,
		SPACE_IRAM,
		SPACE_SPECIAL_FUNCTION_REG,
		SPACE_XRAM,
		SPACE_CODE,
		SPACE_IMM,
		SPACE_ACC
	} oag_space_t;

	// First byte address that belongs to the special function register space.
	localparam logic [7:0] SPECIAL_FUNCTION_REG_BASE = 8'h80;
	// First byte of the bit-addressable internal RAM.
	localparam logic [7:0] BITRAM_BASE = 8'h20;
	// First bit address that maps onto special function register bits.
	localparam logic [7:0] BIT_SPECIAL_FUNCTION_REG_BASE = 8'h80;
	// Field positions inside a bit address.
	localparam int BIT_SEL_LSB = 0;
	localparam int BIT_SEL_MSB = 2;
	localparam int BIT_BYTE_LSB = 3;
	// Top bit of the byte part of a bit address in the RAM region.
	localparam int BIT_RAM_BYTE_MSB = 6;
	// Reset values of the answer.
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] IMM_RST = 8'h00;
	localparam logic [2:0] BIT_RST = 3'h0;

endpackage
`default_nettype wire

// [rtl/oag_bit_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module oag_bit_decode (
	// Bit address from the instruction.
	input  wire logic [7:0] bit_addr,
	// Resolved byte location and bit position.
	output logic      [7:0] byte_addr,
	output logic      [2:0] bit_sel,
	output logic            in_special_function_reg
);

	// Low bit addresses land in the bit RAM, high ones in the special register holding the bit.
	always_comb begin
		bit_sel = bit_addr[oag_pkg::BIT_SEL_MSB:oag_pkg::BIT_SEL_LSB];
		in_special_function_reg = (bit_addr
			>= oag_pkg::BIT_SPECIAL_FUNCTION_REG_BASE);
		if (in_special_function_reg) begin
			// Only special registers on an eight-byte boundary are bit addressable.
			byte_addr = {bit_addr[7:oag_pkg::BIT_BYTE_LSB], 3'h0};
		end else begin
			byte_addr = 8'(oag_pkg::BITRAM_BASE
				+ {4'h0, bit_addr[oag_pkg::BIT_RAM_BYTE_MSB:oag_pkg::BIT_BYTE_LSB]});
		end
	end

endmodule
`default_nettype wire

// [sim/oag_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module oag_mem_model (
	// Clock.
	input  wire logic                clock,
	// Resolved operand from the generator.
	input  wire logic                op_valid,
	input  wire oag_pkg::oag_space_t op_space,
	input  wire logic         [15:0] op_addr,
	// Read data back to the core.
	output logic               [7:0] rd_data
);
	logic [7:0] last_q;

	// Contents are a fixed pattern of address and space, so every read is predictable.
	// Between accesses the bus shows the inverse of the byte it drove one cycle before, so it toggles and repeats the last read every second idle cycle.
	always_comb begin
		if (op_valid) begin
			rd_data = op_addr[15:8] ^ op_addr[7:0] ^ {5'h00, op_space};
		end else begin
			rd_data = ~last_q;
		end
	end

	// Remember the last byte driven.
	always_ff @(posedge clock) begin
		last_q <= rd_data;
	end
endmodule
`default_nettype wire

// [sim/oag_operand_address_generator_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin n_fail++; \
	$display("BAD t=%0t got %h want %h", $time, got, want); end end
module oag_operand_address_generator_tb_top;
	typedef struct packed {
		logic  [2:0] mode;
		logic  [7:0] field;
		logic  [2:0] sel;
		logic  [2:0] flg;
		logic  [1:0] bank;
		logic [33:0] exp;
	} oag_row_t;

	logic                clock, rst_n, req_valid, req_ptr_sel, req_xdata, req_write, req_acc_data;
	oag_pkg::oag_mode_t  req_mode;
	logic          [7:0] req_field, acc, pointer_reg_a, pointer_reg_b, op_imm, rd_data;
	logic          [2:0] req_reg_sel, op_bit_sel;
	logic          [1:0] bank_sel;
	logic         [15:0] data_pointer, op_addr;
	logic                op_valid, op_is_bit, op_spec_byte, op_error;
	oag_pkg::oag_space_t op_space;
	logic         [33:0] out, got;
	oag_row_t            rows[$];
	oag_row_t            r;
	int                  n_fail, num_checks, cycles;

	// The whole answer as one word: valid, space, addr, imm, bit, is_bit, spec_byte, error.
	assign out = {op_valid, op_space, op_addr, op_imm, op_bit_sel, op_is_bit, op_spec_byte, op_error};

	oag_operand_address_generator oag_operand_address_generator_inst (
		.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_mode(req_mode),
		.req_field(req_field), .req_reg_sel(req_reg_sel), .req_ptr_sel(req_ptr_sel),
		.req_xdata(req_xdata), .req_write(req_write), .req_acc_data(req_acc_data),
		.bank_sel(bank_sel), .acc(acc), .data_pointer(data_pointer),
		.pointer_reg_a(pointer_reg_a), .pointer_reg_b(pointer_reg_b), .op_valid(op_valid),
		.op_space(op_space), .op_addr(op_addr), .op_imm(op_imm), .op_bit_sel(op_bit_sel),
		.op_is_bit(op_is_bit), .op_spec_byte(op_spec_byte), .op_error(op_error));

	oag_mem_model oag_mem_model_inst (
		.clock(clock), .op_valid(op_valid), .op_space(op_space), .op_addr(op_addr),
		.rd_data(rd_data));

	// Mode and space are given by their encoding to keep the table narrow.
	task automatic row(input logic [2:0] m, input logic [7:0] f, input logic [2:0] s,
			input logic [2:0] fl, input logic [1:0] b, input logic [2:0] sp,
			input logic [15:0] a, input logic [7:0] im, input logic [2:0] bs, input logic [2:0] ef);
		rows.push_back('{m, f, s, fl, b, {1'b1, sp, a, im, bs, ef}});
	endtask

	// Present one request; it is taken at the next rising edge.
	task automatic drive(input oag_row_t x);
		req_valid <= 1'b1;
		req_mode <= oag_pkg::oag_mode_t'(x.mode);
		req_field <= x.field;
		req_reg_sel <= x.sel;
		req_ptr_sel <= x.sel[0];
		{req_xdata, req_write, req_acc_data} <= x.flg;
		bank_sel <= x.bank;
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// A hang is cut short well past the expected run of about forty cycles.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		n_fail = 0;
		num_checks = 0;
		cycles = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_mode = oag_pkg::MODE_DIRECT;
		req_field = 8'h00;
		req_reg_sel = 3'h0;
		req_ptr_sel = 1'b0;
		{req_xdata, req_write, req_acc_data} = 3'h0;
		bank_sel = 2'h0;
		acc = 8'hf0;
		data_pointer = 16'h12fe;
		pointer_reg_a = 8'h3c;
		pointer_reg_b = 8'ha5;
		// Columns: mode, field, sel, {xdata,write,accdata}, bank, space, addr, imm, bit, flags.
		row(3'h0, 8'h90, 3'h0, 3'h0, 2'h0, 3'h2, 16'h0090, 8'h00, 3'h0, 3'h2);
		row(3'h0, 8'h7f, 3'h0, 3'h0, 2'h0, 3'h1, 16'h007f, 8'h00, 3'h0, 3'h2);
		row(3'h1, 8'h00, 3'h0, 3'h0, 2'h0, 3'h1, 16'h003c, 8'h00, 3'h0, 3'h2);
		row(3'h1, 8'h00, 3'h1, 3'h5, 2'h0, 3'h3, 16'h00a5, 8'h00, 3'h0, 3'h2);
		row(3'h2, 8'h00, 3'h0, 3'h5, 2'h0, 3'h3, 16'h12fe, 8'h00, 3'h0, 3'h2);
		row(3'h3, 8'h00, 3'h5, 3'h0, 2'h2, 3'h1, 16'h0015, 8'h00, 3'h0, 3'h0);
		row(3'h3, 8'h00, 3'h7, 3'h0, 2'h3, 3'h1, 16'h001f, 8'h00, 3'h0, 3'h0);
		row(3'h4, 8'h55, 3'h0, 3'h0, 2'h0, 3'h6, 16'h0000, 8'h00, 3'h0, 3'h0);
		row(3'h5, 8'h5a, 3'h0, 3'h0, 2'h0, 3'h5, 16'h0000, 8'h5a, 3'h0, 3'h2);
		row(3'h6, 8'h00, 3'h0, 3'h0, 2'h0, 3'h4, 16'h13ee, 8'h00, 3'h0, 3'h2);
		row(3'h7, 8'h0b, 3'h0, 3'h0, 2'h0, 3'h1, 16'h0021, 8'h00, 3'h3, 3'h6);
		row(3'h7, 8'h7f, 3'h0, 3'h0, 2'h0, 3'h1, 16'h002f, 8'h00, 3'h7, 3'h6);
		row(3'h7, 8'h80, 3'h0, 3'h0, 2'h0, 3'h2, 16'h0080, 8'h00, 3'h0, 3'h6);
		row(3'h7, 8'hff, 3'h0, 3'h0, 2'h0, 3'h2, 16'h00f8, 8'h00, 3'h7, 3'h6);
		row(3'h6, 8'h00, 3'h0, 3'h2, 2'h0, 3'h0, 16'h0000, 8'h00, 3'h0, 3'h1);
		row(3'h0, 8'h30, 3'h0, 3'h5, 2'h0, 3'h0, 16'h0000, 8'h00, 3'h0, 3'h1);
		row(3'h1, 8'h00, 3'h0, 3'h4, 2'h0, 3'h0, 16'h0000, 8'h00, 3'h0, 3'h1);
		row(3'h2, 8'h00, 3'h0, 3'h1, 2'h0, 3'h0, 16'h0000, 8'h00, 3'h0, 3'h1);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		// Rows go back to back; each answer is checked in the cycle after it is taken.
		for (int i = 0; i <= rows.size(); i++) begin
			@(posedge clock);
			if (i < rows.size()) begin
				drive(rows[i]);
			end else begin
				req_valid <= 1'b0;
			end
			#1;
			if (i > 0) begin
				r = rows[i-1];
				// The specifier flag is left open for refused requests.
				got = r.exp[0] ? {out[33:2], r.exp[1], out[0]} : out;
				`CHK(got, r.exp)
				`CHK(out[0], r.exp[0])
			end
		end
		// Indexed read whose sum wraps past the top of program memory.
		@(posedge clock);
		data_pointer <= 16'hff80;
		drive(rows[9]);
		@(posedge clock);
		req_valid <= 1'b0;
		#1;
		`CHK(out, {1'b1, 3'h4, 16'h0070, 8'h00, 3'h0, 3'h2})
		`CHK(rd_data, 8'h74)
		// Mid-run reset lands just after the edge that takes a request, so the registered answer must be wiped.
		@(posedge clock);
		drive(rows[0]);
		@(posedge clock);
		rst_n <= 1'b0;
		#1;
		`CHK(out, 34'h0)
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) begin
			@(posedge clock);
			#1;
			`CHK(op_valid, 1'b0)
		end
		@(posedge clock);
		#1;
		`CHK(out, rows[0].exp)
		report_and_stop();
	end
endmodule
`default_nettype wire
